//--- audio_pulse_regs.svh
`ifndef AUDIO_PULSE_REGS_SVH
`define AUDIO_PULSE_REGS_SVH

// *****************************************************************
// Timing
// *****************************************************************
`define AUDIO_CLOCK_HZ 250000000
`define AUDIO_BAND_HZ 5000
`define AUDIO_OVERSAMPLE 10
`define AUDIO_MIN_RATE_HZ (`AUDIO_BAND_HZ * `AUDIO_OVERSAMPLE)
`define AUDIO_MAX_PERIOD_CYC (`AUDIO_CLOCK_HZ / `AUDIO_MIN_RATE_HZ)

// *****************************************************************
// Reset values
// *****************************************************************
`define AUDIO_DUTY_RST 8'h80

`endif

//--- audio_pulse_pkg.sv
package audio_pulse_pkg;
   typedef enum logic {mod_pwm_type_val, mod_pdm_type_val} mod_scheme_type;
endpackage

//--- mono_audio_pulse_output.sv
`include "audio_pulse_regs.svh"
// Operation
// - Pulse pin open-drain: low or released only
// - Shutdown control high while audio wanted
// - PWM or PDM chosen at design time
// - PWM: one pulse per fixed period, sample width
// - Average level tracks sample linearly
// - Pulse rate at least ten times bandwidth
// - Pulse rate as high as practical
module mono_audio_pulse_output #(
   parameter int WIDTH = 8,
   parameter audio_pulse_pkg::mod_scheme_type SCHEME =
      audio_pulse_pkg::mod_pwm_type_val
) (
   input wire logic clock, // System clock
   input wire logic rst_n, // Synchronous reset
   input wire logic clk_en, // Freezes state when low
   input wire logic enable, // Audio wanted
   input wire logic sample_valid, // Sample strobe
   input wire logic [WIDTH-1:0] sample, // Unsigned amplitude
   input wire logic audio_pulse_in, // Pin level read back
   output logic audio_pulse_out, // Pin output value, always 0
   output logic audio_pulse_oe_n, // Low pulls pin low
   output logic audio_shutdown_ctrl, // High unmutes
   output logic period_start // Pulse at each period start
);

   // *****************************************************************
   // Parameter checks
   // *****************************************************************
   localparam int PERIOD = 1 << WIDTH;
   localparam int MAX_PERIOD = `AUDIO_MAX_PERIOD_CYC;

   // Refused at elaboration, before any logic is built
   generate
      if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
         $error("WIDTH out of range");
      end
      if (PERIOD > MAX_PERIOD) begin : g_slow_rate
         $error("Pulse rate too low for audio band");
      end
   endgenerate

   // *****************************************************************
   // Sample holding
   // *****************************************************************
   logic [WIDTH-1:0] pend_ff;
   logic [WIDTH-1:0] duty_ff;
   logic [WIDTH-1:0] cnt_ff;
   logic [WIDTH:0] acc_ff;
   logic wrap;
   logic bit_one;

   logic [WIDTH:0] hi_cnt_ff;

   // Last count of a period
   function automatic logic last_step(input logic [WIDTH-1:0] c);
      return c == {WIDTH{1'b1}};
   endfunction

   assign wrap = last_step(cnt_ff);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pend_ff <= WIDTH'(`AUDIO_DUTY_RST);
      end else if (clk_en && sample_valid) begin
         pend_ff <= sample;
      end
   end

   // Latched only at period boundary
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         duty_ff <= WIDTH'(`AUDIO_DUTY_RST);
      end else if (clk_en && wrap) begin
         duty_ff <= (sample_valid) ? sample : pend_ff;
      end
   end

   // *****************************************************************
   // Modulator
   // *****************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (clk_en) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Density accumulator; carry gives the bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_ff <= '0;
      end else if (clk_en) begin
         acc_ff <= {1'b0, acc_ff[WIDTH-1:0]} + {1'b0, duty_ff};
      end
   end

   always_comb begin
      if (SCHEME == audio_pulse_pkg::mod_pwm_type_val) begin
         bit_one = (cnt_ff < duty_ff);
      end else begin
         bit_one = acc_ff[WIDTH];
      end
   end

   // *****************************************************************
   // Check helper
   // *****************************************************************
   // High bits counted over one period, cleared at the boundary
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hi_cnt_ff <= '0;
      end else if (clk_en) begin
         if (wrap) begin
            hi_cnt_ff <= '0;
         end else begin
            hi_cnt_ff <= hi_cnt_ff + (WIDTH+1)'(bit_one);
         end
      end
   end

   // *****************************************************************
   // Pin drivers
   // *****************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         audio_pulse_oe_n <= 1'b0;
         audio_shutdown_ctrl <= 1'b0;
         period_start <= 1'b0;
      end else if (clk_en) begin
         audio_pulse_oe_n <= bit_one & enable;
         audio_shutdown_ctrl <= enable;
         period_start <= wrap;
      end
   end

   always_ff @(posedge clock) begin
      audio_pulse_out <= 1'b0;
   end

   // *****************************************************************
   // Checks
   // *****************************************************************
   // Steps of one period boundary
   sequence s_period_end;
      clk_en && wrap;
   endsequence

   sequence s_period_begin;
      period_start && cnt_ff == '0;
   endsequence

   // Nothing moves while the clock enable is low
   sequence s_frozen;
      $stable(cnt_ff) && $stable(duty_ff) && $stable(acc_ff) &&
         $stable(audio_pulse_oe_n);
   endsequence

   chk_never_high: assert property (
      @(posedge clock) disable iff (!rst_n) !audio_pulse_out)
      else $error("pulse pin driven high");
   chk_shutdown_follows: assert property (
      @(posedge clock) disable iff (!rst_n)
      clk_en |=> audio_shutdown_ctrl == $past(enable))
      else $error("shutdown not following enable");
   chk_duty_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      !wrap |=> $stable(duty_ff))
      else $error("duty changed mid period");
   chk_muted_low: assert property (
      @(posedge clock) disable iff (!rst_n)
      clk_en && !enable |=> !audio_pulse_oe_n)
      else $error("muted output released");
   chk_period_len: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_period_end |=> cnt_ff == '0)
      else $error("period wrong");
   chk_period_mark: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_period_end |=> s_period_begin)
      else $error("period start missing");
   chk_freeze_state: assert property (
      @(posedge clock) disable iff (!rst_n)
      !clk_en |=> s_frozen)
      else $error("state moved while frozen");
   chk_pend_capture: assert property (
      @(posedge clock) disable iff (!rst_n)
      clk_en && sample_valid |=> pend_ff == $past(sample))
      else $error("sample not held");
   chk_reset_state: assert property (
      @(posedge clock)
      !rst_n |=> !audio_shutdown_ctrl && !audio_pulse_oe_n && !period_start)
      else $error("reset state wrong");

   // *****************************************************************
   // Scheme specific checks
   // *****************************************************************
   generate
      if (SCHEME == audio_pulse_pkg::mod_pwm_type_val) begin : g_pwm_chk
         chk_zero_duty: assert property (
            @(posedge clock) disable iff (!rst_n)
            clk_en && enable && duty_ff == '0 |=> !audio_pulse_oe_n)
            else $error("zero duty released pin");
         chk_high_count: assert property (
            @(posedge clock) disable iff (!rst_n)
            s_period_end |->
               hi_cnt_ff + (WIDTH+1)'(bit_one) == (WIDTH+1)'(duty_ff))
            else $error("high time differs from duty");
      end else begin : g_pdm_chk
         chk_density_zero: assert property (
            @(posedge clock) disable iff (!rst_n)
            clk_en && duty_ff == '0 && !acc_ff[WIDTH] |=> !audio_pulse_oe_n)
            else $error("zero density released pin");
      end
   endgenerate

endmodule // mono_audio_pulse_output

//--- audio_filter_model.sv
module audio_filter_model (
   input wire logic pin_oe_n, // Pad release
   output logic pin_level // Pulled-up pad
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up gives the high level only when released
   assign pin_level = pin_oe_n ? 1'b1 : 1'b0;
endmodule // audio_filter_model

//--- mono_audio_pulse_output_bench.sv
module mono_audio_pulse_output_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, enable = 1'b0;
   logic valid = 1'b0;
   logic [7:0] sample = 8'h00;
   logic pin_out, pin_oe_n, shut_ctrl, pstart, pin_level;
   logic pdm_out, pdm_oe_n, pdm_shut, pdm_start;
   int err_count = 0, compares = 0;
   always #2 clock = ~clock;
   mono_audio_pulse_output u_dut (.clock(clock), .rst_n(rst_n),
      .clk_en(clk_en), .enable(enable), .sample_valid(valid),
      .sample(sample), .audio_pulse_in(pin_level),
      .audio_pulse_out(pin_out), .audio_pulse_oe_n(pin_oe_n),
      .audio_shutdown_ctrl(shut_ctrl), .period_start(pstart));
   audio_filter_model u_filter (.pin_oe_n(pin_oe_n),
      .pin_level(pin_level));
   mono_audio_pulse_output #(.SCHEME(audio_pulse_pkg::mod_pdm_type_val))
      u_pdm (.clock(clock), .rst_n(rst_n),
      .clk_en(clk_en), .enable(enable), .sample_valid(valid),
      .sample(sample), .audio_pulse_in(pdm_oe_n),
      .audio_pulse_out(pdm_out), .audio_pulse_oe_n(pdm_oe_n),
      .audio_shutdown_ctrl(pdm_shut), .period_start(pdm_start));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wait_start();
      int n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
         if (n > 600) begin
            err_count++;
            give_verdict();
         end
      end while (pstart !== 1'b1);
   endtask
   task automatic set_duty(input logic [7:0] v);
      @(posedge clock);
      sample <= v;
      valid <= 1'b1;
      @(posedge clock);
      valid <= 1'b0;
   endtask
   // High cycles over one whole period once the duty has settled
   task automatic count_high(input logic [8:0] exp);
      logic [8:0] hi = 9'h000;
      logic [8:0] hi_pdm = 9'h000;
      logic driven_high = 1'b0;
      wait_start();
      wait_start();
      repeat (256) begin
         @(posedge clock);
         #1;
         hi += pin_level;
         hi_pdm += pdm_oe_n;
         driven_high |= pin_out | pdm_out;
      end
      check(hi, exp);
      check(hi_pdm, exp);
      check(driven_high, 9'h000);
   endtask
   task automatic test_duty();
      logic [7:0] duty[3] = '{8'h00, 8'h40, 8'hff};
      foreach (duty[i]) begin
         set_duty(duty[i]);
         count_high({1'b0, duty[i]});
      end
      $display("duty test done");
   endtask
   task automatic test_mute();
      @(posedge clock);
      enable <= 1'b0;
      count_high(9'h000);
      check(shut_ctrl, 9'h000);
      @(posedge clock);
      enable <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check(shut_ctrl, 9'h001);
      $display("mute test done");
   endtask
   task automatic test_late();
      set_duty(8'h40);
      count_high(9'h040);
      wait_start();
      set_duty(8'hc0);
      repeat (100) @(posedge clock);
      #1;
      check(pin_level, 9'h000);
      wait_start();
      repeat (100) @(posedge clock);
      #1;
      check(pin_level, 9'h001);
      $display("late sample test done");
   endtask
   // Twenty frozen cycles stretch the period by twenty
   task automatic test_freeze();
      int n = 1;
      wait_start();
      @(posedge clock);
      clk_en <= 1'b0;
      repeat (20) @(posedge clock);
      clk_en <= 1'b1;
      n += 20;
      do begin
         @(posedge clock);
         #1;
         n++;
         if (n > 600) begin
            err_count++;
            give_verdict();
         end
      end while (pstart !== 1'b1);
      check(9'(n), 9'h114);
      check(shut_ctrl, 9'h001);
      $display("freeze test done");
   endtask
   initial begin
      repeat (5) @(posedge clock);
      #1;
      check({pin_oe_n, shut_ctrl}, 9'h000);
      @(posedge clock);
      rst_n <= 1'b1;
      enable <= 1'b1;
      test_duty();
      test_mute();
      test_late();
      test_freeze();
      give_verdict();
   end
endmodule // mono_audio_pulse_output_bench
